// ---- rtl/tpgpio_pkg.sv ----
package tpgpio_pkg;
  localparam logic [7:0] ADDR_GRP_A_DATA = 8'h05;
  localparam logic [7:0] ADDR_GRP_B_DATA = 8'h06;
  localparam logic [7:0] ADDR_GRP_C_DATA = 8'h07;
  localparam logic [7:0] ADDR_INTR_CTRL = 8'h0b;
  localparam logic [7:0] ADDR_CMP_CTRL = 8'h1f;
  localparam logic [7:0] ADDR_TMR_PU_CFG = 8'h81;
  localparam logic [7:0] ADDR_DIR_A = 8'h85;
  localparam logic [7:0] ADDR_DIR_B = 8'h86;
  localparam logic [7:0] ADDR_DIR_C = 8'h87;
  localparam logic [7:0] ADDR_VREF_CTRL = 8'h9f;
  localparam logic [5:0] RST_DIR_A = 6'h3f;
  localparam logic [7:0] RST_DIR_B = 8'hff;
  localparam logic [7:0] RST_DIR_C = 8'hff;
  localparam logic [7:0] RST_TMR_PU_CFG = 8'hff;
  localparam logic [7:0] RST_CMP_CTRL = 8'h00;
  localparam logic [7:0] RST_VREF_CTRL = 8'h00;
  localparam logic [7:0] RST_INTR_CTRL = 8'h00;
  localparam logic [5:0] RST_LAT_A = 6'h00;
  localparam logic [7:0] RST_LAT_BC = 8'h00;
  localparam int PU_EN_N_BIT = 7;
  localparam int PIN_CHG_FLAG_BIT = 0;
  localparam int PIN_CHG_EN_BIT = 3;
  localparam int TMR_CLK_PIN = 4;
  localparam int VREF_PIN = 2;
  localparam int VREF_OE_BIT = 6;
  localparam int VREF_EN_BIT = 7;
  localparam logic [2:0] CM_MODE_OFF = 3'h7;
  localparam logic [2:0] CM_MODE_RESET = 3'h0;
  localparam logic [2:0] CM_MODE_OUTS = 3'h6;
  localparam logic [7:0] CMP_CTRL_WMASK = 8'h0f;
  localparam logic [7:0] VREF_CTRL_WMASK = 8'hef;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tpgpio_bus_req_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } tpgpio_pin_drv_t;
endpackage

// ---- rtl/tpgpio_top.sv ----
// Contract
// R1: Group A is a six-bit output latch with a direction bit per pin.
// R2: Group A pin four is open-drain only and feeds the timer clock.
// R3: Direction set means high impedance; cleared drives the latch value.
// R4: Data reads return pin levels; writes update only the latch.
// R5: Port writes are read-modify-write into the whole data latch.
// R6: Comparator and reference controls override digital use of group A pins.
// R7: Group A pins selected as comparator inputs read as zero.
// R8: Reset makes group A inputs, digital inputs off, comparator inputs grounded.
// R9: Direction bits still control group A pins used as comparator inputs.
// R10: Software sets pin two direction and uses high-impedance loads for reference.
// R11: In output mode pins three and four carry comparator outputs if driven.
// R12: Group B is eight-bit bidirectional with an eight-bit direction register.
// R13: Clearing pull-up enable bit seven of config enables all group B pull-ups.
// R14: A pull-up is off for output pins and all are off after power-on.
// R15: Change detect covers group B pins seven to four, inputs only.
// R16: Inputs compare with value latched at last group B read; OR sets flag. The code also latches on group B writes.
// R17: The pin change event can wake the device from sleep.
// R18: The flag keeps setting while a mismatch persists.
// R19: Software avoids polling group B while relying on change detect.
// R20: Group C is eight-bit bidirectional with its own direction register.
// R21: The flag sets regardless of individual or global enable bits.
// R22: Group C direction resets to all ones; its latch survives other resets.
// R23: Pin levels pass a synchroniser before reads and change detect.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module tpgpio_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire tpgpio_pkg::tpgpio_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic [5:0] pin_a_i,
  output tpgpio_pkg::tpgpio_pin_drv_t pin_a_drv,
  input wire logic [7:0] pin_b_i,
  output tpgpio_pkg::tpgpio_pin_drv_t pin_b_drv,
  output logic [7:0] pin_b_pullup,
  input wire logic [7:0] pin_c_i,
  output tpgpio_pkg::tpgpio_pin_drv_t pin_c_drv,
  input wire logic [1:0] cmp_out,
  output logic [5:0] cmp_in_gnd,
  output logic timer_ext_clock_in,
  output logic [7:0] comparator_control,
  output logic [7:0] voltage_reference_control,
  output logic [7:0] timer_pullup_config,
  output logic pin_change_flag,
  output logic wake_req
);
  import tpgpio_pkg::*;

  logic [5:0] dir_a_q;
  logic [7:0] dir_b_q;
  logic [7:0] dir_c_q;
  logic [5:0] lat_a_q;
  logic [7:0] lat_b_q;
  logic [7:0] lat_c_q;
  logic [7:0] cmp_ctrl_q;
  logic [7:0] vref_ctrl_q;
  logic [7:0] cfg_q;
  logic [7:0] intr_ctrl_q;
  logic [3:0] chg_ref_q;
  logic [7:0] rdata_q;
  logic pu_off_q;
  logic chg_armed_q;
  tpgpio_pin_drv_t pin_a_drv_q;
  tpgpio_pin_drv_t pin_b_drv_q;
  tpgpio_pin_drv_t pin_c_drv_q;
  logic [7:0] pullup_q;
  logic [5:0] cmp_gnd_q;
  logic wake_q;
  logic tmr_clk_q;
  logic [23:0] sync1_q;
  logic [23:0] sync2_q;
  logic [23:0] sync3_q;
  logic [23:0] pins_q;

  // Three-stage sampler, level accepted when stages two and three agree
  // Comparator results are asynchronous as well, so they share it
  wire [23:0] raw_pins = {cmp_out, pin_c_i, pin_b_i, pin_a_i};
  wire [23:0] agree = ~(sync2_q ^ sync3_q);
  wire [23:0] pins_d = (agree & sync3_q) | (~agree & pins_q);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      pins_q <= '0;
    end else begin
      sync1_q <= raw_pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pins_q <= pins_d; // R23
    end
  end
  wire [5:0] lvl_a = pins_q[5:0];
  wire [7:0] lvl_b = pins_q[13:6];
  wire [7:0] lvl_c = pins_q[21:14];
  wire [1:0] cmp_lvl = pins_q[23:22];

  // Comparator pin function decode
  wire [2:0] cm_mode = cmp_ctrl_q[2:0];
  wire cm_off = (cm_mode == CM_MODE_OFF);
  wire cm_reset_mode = (cm_mode == CM_MODE_RESET);
  wire cm_outs = (cm_mode == CM_MODE_OUTS);
  wire [5:0] analog_in = cm_off ? 6'h00 : (cm_outs ? 6'h07 : 6'h0f); // R6
  wire vref_out = vref_ctrl_q[VREF_EN_BIT] & vref_ctrl_q[VREF_OE_BIT];
  wire [5:0] analog_sel = analog_in | (vref_out ? 6'h04 : 6'h00); // R6

  // Bus decode
  wire wr_a = bus_req.wr && (bus_req.addr == ADDR_GRP_A_DATA);
  wire wr_b = bus_req.wr && (bus_req.addr == ADDR_GRP_B_DATA);
  wire wr_c = bus_req.wr && (bus_req.addr == ADDR_GRP_C_DATA);
  wire wr_intr = bus_req.wr && (bus_req.addr == ADDR_INTR_CTRL);
  wire wr_cmp = bus_req.wr && (bus_req.addr == ADDR_CMP_CTRL);
  wire wr_cfg = bus_req.wr && (bus_req.addr == ADDR_TMR_PU_CFG);
  wire wr_dir_a = bus_req.wr && (bus_req.addr == ADDR_DIR_A);
  wire wr_dir_b = bus_req.wr && (bus_req.addr == ADDR_DIR_B);
  wire wr_dir_c = bus_req.wr && (bus_req.addr == ADDR_DIR_C);
  wire wr_vref = bus_req.wr && (bus_req.addr == ADDR_VREF_CTRL);
  wire rd_b = bus_req.rd && (bus_req.addr == ADDR_GRP_B_DATA);

  wire [5:0] read_a = lvl_a & ~analog_sel; // R7
  logic [7:0] rd_mux;
  always_comb begin
    if (bus_req.addr == ADDR_GRP_A_DATA) begin
      rd_mux = {2'b00, read_a}; // R4
    end else if (bus_req.addr == ADDR_GRP_B_DATA) begin
      rd_mux = lvl_b; // R4
    end else if (bus_req.addr == ADDR_GRP_C_DATA) begin
      rd_mux = lvl_c; // R4
    end else if (bus_req.addr == ADDR_INTR_CTRL) begin
      rd_mux = intr_ctrl_q;
    end else if (bus_req.addr == ADDR_CMP_CTRL) begin
      rd_mux = {cmp_lvl, 2'b00, cmp_ctrl_q[3:0]};
    end else if (bus_req.addr == ADDR_TMR_PU_CFG) begin
      rd_mux = cfg_q;
    end else if (bus_req.addr == ADDR_DIR_A) begin
      rd_mux = {2'b00, dir_a_q};
    end else if (bus_req.addr == ADDR_DIR_B) begin
      rd_mux = dir_b_q;
    end else if (bus_req.addr == ADDR_DIR_C) begin
      rd_mux = dir_c_q;
    end else if (bus_req.addr == ADDR_VREF_CTRL) begin
      rd_mux = vref_ctrl_q & VREF_CTRL_WMASK;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Write value replaces whole latch; bus master supplies the modified pin image
  wire [5:0] lat_a_d = wr_a ? bus_req.wdata[5:0] : lat_a_q; // R5
  wire [7:0] lat_b_d = wr_b ? bus_req.wdata : lat_b_q; // R5
  wire [7:0] lat_c_d = wr_c ? bus_req.wdata : lat_c_q; // R5
  wire [5:0] dir_a_d = wr_dir_a ? bus_req.wdata[5:0] : dir_a_q; // R1
  wire [7:0] dir_b_d = wr_dir_b ? bus_req.wdata : dir_b_q; // R12
  wire [7:0] dir_c_d = wr_dir_c ? bus_req.wdata : dir_c_q; // R20
  wire [7:0] cmp_ctrl_d = wr_cmp ? (bus_req.wdata & CMP_CTRL_WMASK) : cmp_ctrl_q;
  wire [7:0] vref_ctrl_d = wr_vref ? (bus_req.wdata & VREF_CTRL_WMASK) : vref_ctrl_q;
  wire [7:0] cfg_d = wr_cfg ? bus_req.wdata : cfg_q;
  wire [7:0] rdata_d = bus_req.rd ? rd_mux : 8'h00;

  // Change detect on upper group B inputs
  wire [3:0] upper_in = lvl_b[7:4];
  // No reference exists until the first group B access, so no false change after reset
  wire chg_armed_d = chg_armed_q || rd_b || wr_b;
  wire [3:0] mismatch = (upper_in ^ chg_ref_q) & dir_b_q[7:4] & {4{chg_armed_q}}; // R15
  wire chg_event = |mismatch; // R16
  wire [3:0] chg_ref_d = (rd_b || wr_b) ? upper_in : chg_ref_q; // R18
  logic [7:0] intr_d;
  always_comb begin
    intr_d = wr_intr ? bus_req.wdata : intr_ctrl_q;
    // Set wins over software clear
    if (chg_event) begin
      intr_d[PIN_CHG_FLAG_BIT] = 1'b1; // R21
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_a_q <= RST_DIR_A; // R8
    end else begin
      dir_a_q <= dir_a_d; // R1
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_b_q <= RST_DIR_B;
    end else begin
      dir_b_q <= dir_b_d; // R12
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_c_q <= RST_DIR_C; // R22
    end else begin
      dir_c_q <= dir_c_d; // R20
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmp_ctrl_q <= RST_CMP_CTRL; // R8
    end else begin
      cmp_ctrl_q <= cmp_ctrl_d; // R6
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vref_ctrl_q <= RST_VREF_CTRL;
    end else begin
      vref_ctrl_q <= vref_ctrl_d; // R6
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= RST_TMR_PU_CFG;
    end else begin
      cfg_q <= cfg_d; // R13
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intr_ctrl_q <= RST_INTR_CTRL;
    end else begin
      intr_ctrl_q <= intr_d; // R16
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chg_ref_q <= 4'h0;
    end else begin
      chg_ref_q <= chg_ref_d; // R16
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chg_armed_q <= 1'b0;
    end else begin
      chg_armed_q <= chg_armed_d; // R16
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lat_a_q <= RST_LAT_A;
    end else begin
      lat_a_q <= lat_a_d; // R1
    end
  end

  // Read data stands for one cycle only, zero otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d; // R4
    end
  end

  // Group B and C latches keep their value across resets other than power-on
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      lat_b_q <= RST_LAT_BC;
    end else begin
      lat_b_q <= lat_b_d;
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      lat_c_q <= RST_LAT_BC; // R22
    end else begin
      lat_c_q <= lat_c_d;
    end
  end

  // Pull-ups stay off until the second edge after power-on release
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      pu_off_q <= 1'b1;
    end else begin
      pu_off_q <= 1'b0; // R14
    end
  end

  // Pin drivers
  logic [5:0] a_o;
  logic [5:0] a_oe;
  always_comb begin
    a_o = lat_a_q;
    a_oe = ~dir_a_q; // R3 R9
    if (cm_outs) begin
      a_o[3] = cmp_lvl[0]; // R11
      a_o[TMR_CLK_PIN] = cmp_lvl[1]; // R11
    end
    // Open-drain: drive only a low
    a_oe[TMR_CLK_PIN] = ~dir_a_q[TMR_CLK_PIN] & ~a_o[TMR_CLK_PIN]; // R2
    a_o[TMR_CLK_PIN] = 1'b0; // R2
  end

  wire [7:0] pullup_d = (cfg_q[PU_EN_N_BIT] || pu_off_q) ? 8'h00 : dir_b_q; // R13 R14
  wire [5:0] cmp_gnd_d = cm_reset_mode ? 6'h0f : 6'h00; // R8
  wire wake_d = chg_event && intr_ctrl_q[PIN_CHG_EN_BIT]; // R17

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_a_drv_q <= '0;
    end else begin
      pin_a_drv_q <= {2'b00, a_o, 2'b00, a_oe}; // R3
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_b_drv_q <= '0;
    end else begin
      pin_b_drv_q <= {lat_b_q, ~dir_b_q}; // R3
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_c_drv_q <= '0;
    end else begin
      pin_c_drv_q <= {lat_c_q, ~dir_c_q}; // R3
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pullup_q <= 8'h00;
    end else begin
      pullup_q <= pullup_d; // R13 R14
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmp_gnd_q <= 6'h0f;
    end else begin
      cmp_gnd_q <= cmp_gnd_d; // R8
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d; // R17
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmr_clk_q <= 1'b0;
    end else begin
      tmr_clk_q <= lvl_a[TMR_CLK_PIN]; // R2
    end
  end

  assign pin_a_drv = pin_a_drv_q;
  assign pin_b_drv = pin_b_drv_q;
  assign pin_c_drv = pin_c_drv_q;
  assign pin_b_pullup = pullup_q;
  assign cmp_in_gnd = cmp_gnd_q;
  assign wake_req = wake_q;
  assign timer_ext_clock_in = tmr_clk_q;
  assign rdata = rdata_q;
  assign comparator_control = cmp_ctrl_q;
  assign voltage_reference_control = vref_ctrl_q;
  assign timer_pullup_config = cfg_q;
  assign pin_change_flag = intr_ctrl_q[PIN_CHG_FLAG_BIT];
endmodule
`default_nettype wire

// ---- testbench/tpgpio_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpgpio_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire tpgpio_pkg::tpgpio_bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire tpgpio_pkg::tpgpio_pin_drv_t pin_a_drv,
  input wire tpgpio_pkg::tpgpio_pin_drv_t pin_c_drv,
  input wire logic [7:0] pin_b_pullup,
  input wire logic [5:0] cmp_in_gnd,
  input wire logic [7:0] comparator_control,
  input wire logic [7:0] timer_pullup_config,
  input wire logic pin_change_flag,
  input wire logic wake_req
);
  import tpgpio_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn || !por_n);
  od_pin_four_a: assert property (pin_a_drv.o[4] == 1'b0)
    else $error("pin four sourced high");
  rd_idle_zero_a: assert property (!bus_req.rd |=> rdata == 8'h00)
    else $error("read data outside slot");
  cfg_readback_a: assert property (bus_req.rd && bus_req.addr == ADDR_TMR_PU_CFG |=>
    rdata == $past(timer_pullup_config)) else $error("config readback wrong");
  dir_c_hiz_a: assert property (bus_req.wr && bus_req.addr == ADDR_DIR_C |->
    ##2 pin_c_drv.oe == ~$past(bus_req.wdata, 2)) else $error("direction c wrong");
  latch_c_data_a: assert property (bus_req.wr && bus_req.addr == ADDR_GRP_C_DATA |->
    ##2 (pin_c_drv.o & pin_c_drv.oe) == ($past(bus_req.wdata, 2) & pin_c_drv.oe))
    else $error("group c latch wrong");
  pullup_off_a: assert property ($past(timer_pullup_config[PU_EN_N_BIT]) |->
    pin_b_pullup == 8'h00) else $error("pull-up on while disabled");
  flag_hold_a: assert property (pin_change_flag &&
    !(bus_req.wr && bus_req.addr == ADDR_INTR_CTRL) |=> pin_change_flag)
    else $error("change flag dropped");
  wake_flag_a: assert property (wake_req |-> pin_change_flag)
    else $error("wake without flag");
  gnd_mode_a: assert property ($past(comparator_control[2:0]) == CM_MODE_RESET |->
    cmp_in_gnd == 6'h0f) else $error("inputs not grounded");
endmodule
bind tpgpio_top tpgpio_chk tpgpio_chk_inst (.clk, .rstn, .por_n, .bus_req, .rdata,
  .pin_a_drv, .pin_c_drv, .pin_b_pullup, .cmp_in_gnd, .comparator_control,
  .timer_pullup_config, .pin_change_flag, .wake_req);
`default_nettype wire

// ---- testbench/tpgpio_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpgpio_pins (
  input wire tpgpio_pkg::tpgpio_pin_drv_t pin_a_drv,
  input wire tpgpio_pkg::tpgpio_pin_drv_t pin_b_drv,
  input wire tpgpio_pkg::tpgpio_pin_drv_t pin_c_drv,
  input wire logic [7:0] pin_b_pullup,
  input wire logic [5:0] a_ext,
  input wire logic [7:0] b_ext,
  input wire logic [7:0] b_en,
  input wire logic [7:0] c_ext,
  output logic [5:0] pin_a_i,
  output logic [7:0] pin_b_i,
  output logic [7:0] pin_c_i
);
  import tpgpio_pkg::*;
  wire [7:0] b_oe = pin_b_drv.oe;
  // Pin four only sinks
  assign pin_a_i = (pin_a_drv.oe[5:0] & pin_a_drv.o[5:0] & 6'h2f)
    | (~pin_a_drv.oe[5:0] & a_ext);
  // Floating line without pull-up shows inverse of latch
  assign pin_b_i = (b_oe & pin_b_drv.o) | (~b_oe & b_en & b_ext)
    | (~b_oe & ~b_en & (pin_b_pullup | ~pin_b_drv.o));
  assign pin_c_i = (pin_c_drv.oe & pin_c_drv.o) | (~pin_c_drv.oe & c_ext);
endmodule
`default_nettype wire

// ---- testbench/tpgpio_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module tpgpio_top_test;
  import tpgpio_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic por_n = 1'b0;
  tpgpio_bus_req_t bus_req = '0;
  logic [7:0] rdata, pin_b_i, pin_c_i, pin_b_pullup, b_ext = 8'h00, b_en = 8'h00;
  logic [7:0] c_ext = 8'h3c;
  logic [5:0] pin_a_i, cmp_in_gnd, a_ext = 6'h00;
  tpgpio_pin_drv_t pin_a_drv, pin_b_drv, pin_c_drv;
  logic timer_ext_clock_in, pin_change_flag, wake_req;
  logic [7:0] comparator_control, voltage_reference_control, timer_pullup_config;
  logic [1:0] cmp_out = 2'b00;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  tpgpio_top tpgpio_top_inst (.clk, .rstn, .por_n, .bus_req, .rdata, .pin_a_i,
    .pin_a_drv, .pin_b_i, .pin_b_drv, .pin_b_pullup, .pin_c_i, .pin_c_drv,
    .cmp_out, .cmp_in_gnd, .timer_ext_clock_in, .comparator_control,
    .voltage_reference_control, .timer_pullup_config, .pin_change_flag, .wake_req);
  tpgpio_pins tpgpio_pins_inst (.pin_a_drv, .pin_b_drv, .pin_c_drv, .pin_b_pullup,
    .a_ext, .b_ext, .b_en, .c_ext, .pin_a_i, .pin_b_i, .pin_c_i);
  task automatic give_verdict();
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic t_regs();
    chk({pin_b_pullup, 2'b00, cmp_in_gnd}, 16'h000f);
    chk({pin_a_drv.oe, pin_c_drv.oe}, 16'h0000);
    rdc(ADDR_DIR_A, 8'h3f);
    rdc(ADDR_DIR_B, 8'hff);
    rdc(ADDR_DIR_C, 8'hff);
    rdc(ADDR_TMR_PU_CFG, 8'hff);
    wr(8'h40, 8'h55);
    rdc(8'h40, 8'h00);
    wr(ADDR_CMP_CTRL, 8'hff);
    chk(comparator_control, 8'h0f);
    rdc(ADDR_CMP_CTRL, 8'h0f);
    wr(ADDR_VREF_CTRL, 8'hff);
    chk(voltage_reference_control, 8'hef);
    rdc(ADDR_VREF_CTRL, 8'hef);
    wr(ADDR_VREF_CTRL, 8'h00);
  endtask
  task automatic t_grp_c();
    wr(ADDR_DIR_C, 8'h0f);
    wr(ADDR_GRP_C_DATA, 8'ha5);
    settle();
    chk(pin_c_drv.oe, 8'hf0);
    rdc(ADDR_GRP_C_DATA, 8'hac);
    wr(ADDR_DIR_C, 8'h00);
    settle();
    chk(pin_c_drv.o, 8'ha5);
  endtask
  task automatic t_grp_a();
    a_ext <= 6'h3f;
    cmp_out <= 2'b01;
    wr(ADDR_DIR_A, 8'h00);
    wr(ADDR_GRP_A_DATA, 8'h3f);
    settle();
    chk({pin_a_drv.oe[5:0], pin_a_drv.o[5:0]}, 16'h0bef);
    rdc(ADDR_GRP_A_DATA, 8'h3f);
    wr(ADDR_DIR_A, 8'h3f);
    wr(ADDR_VREF_CTRL, 8'hc0);
    rdc(ADDR_GRP_A_DATA, 8'h3b);
    wr(ADDR_VREF_CTRL, 8'h00);
    wr(ADDR_CMP_CTRL, 8'h02);
    settle();
    rdc(ADDR_GRP_A_DATA, 8'h30);
    chk(timer_ext_clock_in, 1'b1);
    wr(ADDR_DIR_A, 8'h27);
    wr(ADDR_CMP_CTRL, {5'h00, CM_MODE_OUTS});
    settle();
    chk(pin_a_drv.oe[4:3], 2'b11);
    chk(pin_a_drv.o[4:3], 2'b01);
    rdc(ADDR_CMP_CTRL, 8'h46);
  endtask
  task automatic t_pullup();
    wr(ADDR_DIR_B, 8'h0f);
    wr(ADDR_TMR_PU_CFG, 8'h7f);
    chk(timer_pullup_config, 8'h7f);
    settle();
    chk(pin_b_pullup, 8'h0f);
    por_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(pin_b_pullup, 8'h00);
    por_n <= 1'b1;
    wr(ADDR_TMR_PU_CFG, 8'hff);
    settle();
    chk(pin_b_pullup, 8'h00);
  endtask
  task automatic t_change();
    b_en <= 8'hff;
    wr(ADDR_DIR_B, 8'h3f);
    wr(ADDR_GRP_B_DATA, 8'h00);
    settle();
    rdc(ADDR_GRP_B_DATA, 8'h00);
    wr(ADDR_INTR_CTRL, 8'h00);
    chk(pin_change_flag, 1'b0);
    b_ext <= 8'h20;
    settle();
    chk(pin_change_flag, 1'b1);
    wr(ADDR_INTR_CTRL, 8'h00);
    chk(pin_change_flag, 1'b1);
    rdc(ADDR_GRP_B_DATA, 8'h20);
    wr(ADDR_INTR_CTRL, 8'h00);
    chk(pin_change_flag, 1'b0);
    wr(ADDR_GRP_B_DATA, 8'hc0);
    b_ext <= 8'h2f;
    settle();
    chk(pin_change_flag, 1'b0);
    chk(pin_b_drv, 16'hc0c0);
    wr(ADDR_INTR_CTRL, 8'h08);
    b_ext <= 8'h10;
    settle();
    chk({wake_req, pin_change_flag}, 2'b11);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    por_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_grp_c();
    t_grp_a();
    t_pullup();
    t_change();
    give_verdict();
  end
endmodule
`default_nettype wire
